// ---- logic/twl_pkg.sv ----
// Constants for the three-wire latch write port.
// Assumes a system clock domain plus the host's serial clock domain.
package twl_pkg;
    // =========================================
    // Word layout
    localparam int WORD_W = 24;
    localparam int SEL_LO = 0;
    localparam int SEL_HI = 1;
    localparam logic [1:0] SEL_REF = 2'h0;
    localparam logic [1:0] SEL_FB = 2'h1;
    localparam logic [1:0] SEL_FUNC = 2'h2;
    localparam logic [1:0] SEL_INIT = 2'h3;
    // =========================================
    // Monitor select field in the function latch
    localparam int MON_LO = 4;
    localparam int MON_W = 3;
    localparam logic [2:0] MON_LOW = 3'h0;
    localparam logic [2:0] MON_LOCK = 3'h1;
    localparam logic [2:0] MON_HIGH = 3'h7;
    localparam logic [WORD_W-1:0] LATCH_RST = 24'h000000;
    // =========================================
    // Timing
    localparam int CLK_MHZ = 125;
    localparam int SCLK_MAX_MHZ = 20;
    localparam int PULSE_NS = 8;
    localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
endpackage

// ---- logic/twl_shift.sv ----
// Serial-clock side: 24-bit input shift register; the load strobe is handled in twl_port.
// Assumes sclk runs only while the host shifts a word.
`timescale 1ns/1ns
module twl_shift
    import twl_pkg::*;
(
    input wire logic sclk,
    input wire logic reset,
    input wire logic sdata,
    output logic [twl_pkg::WORD_W-1:0] shift_q
);
    // =========================================
    // Shift in
    // sample on rising edge
    // oldest bits drop out the top
    always_ff @(posedge sclk or posedge reset) begin
        if (reset) begin
            shift_q <= '0;
        end else begin
            shift_q <= {shift_q[WORD_W-2:0], sdata};
        end
    end
endmodule

// ---- logic/twl_port.sv ----
// Contract
// - Data sampled each rising serial clock edge into a 24-bit shift register.
// - Strobe rising edge copies 24-bit word into addressed latch.
// - Monitor pin carries a selectable signal, lock indication among them.
// - Chip enable low powers down; high returns to operation.
// - Two low bits select latch: ref, feedback, function, init.
// - Init load pulses counter reset; first feedback load after pulses again.
//
// Top of the write port: shift register on sclk, latches on clk.
// Assumes the host leaves sclk still while the strobe rises.
`timescale 1ns/1ns
module twl_port
    import twl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic load_strobe,
    input wire logic chip_enable,
    input wire logic lock_indicator,
    output logic monitor_output_pin,
    output logic power_down,
    output logic counter_reset_pulse,
    output logic [twl_pkg::WORD_W-1:0] ref_latch,
    output logic [twl_pkg::WORD_W-1:0] fb_latch,
    output logic [twl_pkg::WORD_W-1:0] func_latch,
    output logic [twl_pkg::WORD_W-1:0] init_latch,
    output logic [3:0] latch_loaded
);
    import twl_pkg::*;


    // =========================================
    // Local sizes and indices
    localparam int N_SYNC = 3;
    localparam int N_LATCH = 4;
    localparam int IDX_STROBE = 0;
    localparam int IDX_CE = 1;
    localparam int IDX_LOCK = 2;

    // =========================================
    // Declarations
    logic [WORD_W-1:0] shift_w;
    logic [N_SYNC-1:0] async_w;
    logic [N_SYNC-1:0] sync_w;
    logic strobe_dly_q;
    logic [N_LATCH-1:0] ld_w;
    logic [N_LATCH-1:0] wr_w;
    logic [WORD_W-1:0] latch_w [N_LATCH];
    logic [N_LATCH-1:0] loaded_q;
    logic [N_LATCH-1:0] loaded_d;
    logic rearm_q;
    logic rearm_d;
    logic pulse_q;
    logic pd_q;
    logic mon_q;

    // =========================================
    // Serial side
    // the shifter runs on the host's clock
    twl_shift u_shift (
        .sclk(sclk),
        .reset(reset),
        .sdata(sdata),
        .shift_q(shift_w)
    );

    // =========================================
    // Crossings
    // Strobe, enable and lock flag are all asynchronous to clk.
    // Only the second flop is read; the first may still be settling.
    assign async_w[IDX_STROBE] = load_strobe;
    assign async_w[IDX_CE] = chip_enable;
    assign async_w[IDX_LOCK] = lock_indicator;

    genvar gs;
    generate
        for (gs = 0; gs < N_SYNC; gs++) begin : g_sync
            logic meta_q;
            logic sync_q;

            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= async_w[gs];
                    sync_q <= meta_q;
                end
            end

            assign sync_w[gs] = sync_q;
        end
    endgenerate

    // One more flop on the strobe gives the edge detector its history.
    // Limitation: a strobe held high through reset reads as one load.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            strobe_dly_q <= 1'b0;
        end else begin
            strobe_dly_q <= sync_w[IDX_STROBE];
        end
    end

    // =========================================
    // Decode
    // The word crosses without its own synchroniser: the host keeps sclk
    // still while the strobe is high-going, so it is quiet for the two
    // synchroniser cycles before the edge is acted on.
    // strobe rising edge
    wire load_w = sync_w[IDX_STROBE] & ~strobe_dly_q;

    wire [1:0] sel_w = {shift_w[SEL_HI], shift_w[SEL_LO]};
    wire ld_ref = load_w && (sel_w == SEL_REF);
    wire ld_fb = load_w && (sel_w == SEL_FB);
    wire ld_func = load_w && (sel_w == SEL_FUNC);
    wire ld_init = load_w && (sel_w == SEL_INIT);

    // Bit positions follow the select codes
    assign ld_w = {ld_init, ld_func, ld_fb, ld_ref};

    // Init load also rewrites the function latch contents
    assign wr_w = ld_w | {1'b0, ld_init, 2'b00};

    // init pulses, first feedback load pulses again
    wire pulse_w = ld_init || (ld_fb && rearm_q);

    wire [MON_W-1:0] mon_sel_w = latch_w[SEL_FUNC][MON_LO +: MON_W];

    // monitor selection; unused codes drive low
    wire mon_w = (mon_sel_w == MON_LOCK) ? sync_w[IDX_LOCK] :
                 (mon_sel_w == MON_HIGH) ? 1'b1 : 1'b0;

    // =========================================
    // Latches
    // copy the word into the addressed latch
    genvar gl;
    generate
        for (gl = 0; gl < N_LATCH; gl++) begin : g_latch
            logic [WORD_W-1:0] word_q;

            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    word_q <= LATCH_RST;
                end else if (wr_w[gl]) begin
                    word_q <= shift_w;
                end
            end

            assign latch_w[gl] = word_q;
        end
    endgenerate

    // =========================================
    // Status
    // Sticky record of which latches were addressed by a load since reset; an init load does not mark the function latch
    assign loaded_d = loaded_q | ld_w;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            loaded_q <= '0;
        end else begin
            loaded_q <= loaded_d;
        end
    end

    // rearm on init, spent on the next feedback load
    assign rearm_d = ld_init ? 1'b1 : (ld_fb ? 1'b0 : rearm_q);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rearm_q <= 1'b0;
        end else begin
            rearm_q <= rearm_d;
        end
    end

    // One cycle wide, lined up with the latch update
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= pulse_w;
        end
    end

    // =========================================
    // Pins
    // chip enable low powers down
    // Reset holds the part down until the synchronised enable says otherwise.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pd_q <= 1'b1;
        end else begin
            pd_q <= ~sync_w[IDX_CE];
        end
    end

    // Registered so the pin never glitches while the select field changes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mon_q <= 1'b0;
        end else begin
            mon_q <= mon_w;
        end
    end

    // =========================================
    // Outputs
    // Every output comes straight from a flop.
    assign ref_latch = latch_w[SEL_REF];
    assign fb_latch = latch_w[SEL_FB];
    assign func_latch = latch_w[SEL_FUNC];
    assign init_latch = latch_w[SEL_INIT];
    assign latch_loaded = loaded_q;
    assign counter_reset_pulse = pulse_q;
    assign power_down = pd_q;
    assign monitor_output_pin = mon_q;
endmodule

// ---- testbench/twl_props.sv ----
// Checker on the write port outputs.
// Assumes it is bound into twl_port.
`timescale 1ns/1ns
module twl_props
    import twl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic load_strobe,
    input wire logic chip_enable,
    input wire logic lock_indicator,
    input wire logic monitor_output_pin,
    input wire logic power_down,
    input wire logic counter_reset_pulse,
    input wire logic [twl_pkg::WORD_W-1:0] func_latch,
    input wire logic [3:0] latch_loaded
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // =========================================
    // Strobe rise seen three edges back
    sequence s_load;
        $past(load_strobe, 3) && !$past(load_strobe, 4);
    endsequence
    chk_pulse_time: assert property (counter_reset_pulse |-> s_load) else $error("pulse off load");
    chk_pulse_single: assert property (counter_reset_pulse |=> !counter_reset_pulse) else $error("long pulse");
    chk_load_time: assert property ($changed(latch_loaded) |-> s_load) else $error("load off strobe");
    chk_init_pulse: assert property ($rose(latch_loaded[3]) |-> counter_reset_pulse) else $error("no pulse");
    chk_pd_on: assert property (!chip_enable [*4] |=> power_down) else $error("not down");
    chk_pd_off: assert property (chip_enable [*4] |=> !power_down) else $error("still down");
    chk_mon_low: assert property ((func_latch[6:4] == MON_LOW) [*2] |-> !monitor_output_pin) else $error("mon");
    chk_mon_high: assert property ((func_latch[6:4] == MON_HIGH) [*2] |-> monitor_output_pin) else $error("mon");
    chk_mon_lock: assert property ((func_latch[6:4] == MON_LOCK && lock_indicator) [*5] |-> monitor_output_pin)
        else $error("mon lock");
endmodule

// ---- testbench/twl_host.sv ----
// Host serial master model.
// Assumes frames start just after a system clock edge.
`timescale 1ns/1ns
module twl_host
    import twl_pkg::*;
(
    output logic sclk,
    output logic sdata,
    output logic load_strobe
);
    // Idle: clock still, strobe low so reset release sees no edge
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        load_strobe = 1'b0;
    end
    // =========================================
    // strobe low, word MSB first at 6.25 MHz, strobe high
    task automatic send(input logic [WORD_W-1:0] w, input logic [7:0] junk, input bit extra);
        logic [31:0] v;
        v = {junk, w};
        load_strobe = 1'b0;
        #80;
        for (int i = extra ? 31 : WORD_W - 1; i >= 0; i--) begin
            sdata = v[i];
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        // Released line shows the inverse, never a stale bit
        sdata = ~sdata;
        #80 load_strobe = 1'b1;
        #80;
    endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the three-wire latch write port.
// Assumes twl_host drives the serial side.
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench;
    import twl_pkg::*;
    logic clk, reset, sclk, sdata, load_strobe, chip_enable, lock_indicator, mon, pd, pulse, armed;
    logic [WORD_W-1:0] rl, fl, ul, il, e[4];
    logic [3:0] ld;
    logic [4*WORD_W:0] q[$], prev, x;
    logic [1:0] seq[6] = '{SEL_INIT, SEL_FUNC, SEL_REF, SEL_FB, SEL_FB, SEL_REF};
    logic [2:0] mc[3] = '{MON_LOW, MON_LOCK, MON_HIGH};
    int n_mismatch = 0, n_checks = 0;
    twl_host host (.sclk(sclk), .sdata(sdata), .load_strobe(load_strobe));
    twl_port dut (.clk(clk), .reset(reset), .sclk(sclk), .sdata(sdata), .load_strobe(load_strobe),
        .chip_enable(chip_enable), .lock_indicator(lock_indicator), .monitor_output_pin(mon), .power_down(pd),
        .counter_reset_pulse(pulse), .ref_latch(rl), .fb_latch(fl), .func_latch(ul), .init_latch(il),
        .latch_loaded(ld));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic write(input logic [1:0] sel, input logic [21:0] hi, input bit extra);
        e[sel] = {hi, sel};
        if (sel == SEL_INIT) e[SEL_FUNC] = {hi, sel};
        q.push_back({sel == SEL_INIT || (sel == SEL_FB && armed), e[0], e[1], e[2], e[3]});
        armed = sel == SEL_INIT || (armed && sel != SEL_FB);
        @(posedge clk);
        #1 host.send({hi, sel}, 8'($urandom), extra);
    endtask
    always @(posedge clk) begin
        if (!reset && {rl, fl, ul, il} !== prev[4*WORD_W-1:0]) begin
            x = q.pop_front();
            `CHK({pulse, rl, fl, ul, il}, x)
        end
        prev <= {pulse, rl, fl, ul, il};
    end
    initial begin
        {reset, chip_enable, lock_indicator, armed} = 4'h8;
        e = '{default: LATCH_RST};
        void'($urandom(32'h70aa33dc));
        repeat (16) @(posedge clk);
        #1 reset = 1'b0;
        // power-up order, then a repeated feedback load without pulse
        foreach (seq[i]) write(seq[i], 22'($urandom), 1'b0);
        // monitor codes low, lock and high, extra leading bits, enable and lock toggled
        foreach (mc[i]) begin
            write(SEL_FUNC, {17'($urandom), mc[i], 2'($urandom)}, 1'b1);
            repeat (6) begin
                repeat (8) @(posedge clk);
                #1 `CHK(pd, !chip_enable)
                `CHK(mon, (mc[i] == MON_HIGH) || (mc[i] == MON_LOCK && lock_indicator))
                {lock_indicator, chip_enable} = 2'($urandom);
            end
        end
        for (int i = 0; i < 200 && q.size() > 0; i++) @(posedge clk);
        `CHK(q.size(), 0)
        `CHK(ld, 4'hf)
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
endmodule
bind twl_port twl_props chk (.clk(clk), .reset(reset), .load_strobe(load_strobe), .chip_enable(chip_enable),
    .lock_indicator(lock_indicator), .monitor_output_pin(monitor_output_pin), .power_down(power_down),
    .counter_reset_pulse(counter_reset_pulse), .func_latch(func_latch), .latch_loaded(latch_loaded));
